// file: verilog/power_state_map.vh
// Constants for the power state and reset control block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 125 MHz core clock.
`ifndef POWER_STATE_MAP_VH
`define POWER_STATE_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_EVENT_STATUS_FLAGS 8'h0F
`define OFS_INTERRUPT_ENABLE_MASK 8'h12
`define OFS_OSCILLATOR_SELECT_CONTROL 8'h1C
`define OFS_BATTERY_THRESHOLD_CONTROL 8'h21
`define OFS_BACKUP_MODE_IO_CONTROL 8'h27
`define OFS_COMPARATOR_LEVEL_STATUS 8'h2F
`define OFS_PIN_OUTPUT_CONTROL 8'h30
`define OFS_EXTENSION_MEMORY_SELECT 8'h3F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_BATTERY_LOW_FLAG 4
`define BIT_ON_BACKUP_FLAG 7
`define BIT_BATTERY_LOW_IRQ_ENABLE 4
`define BIT_OSC_SELECT_RC 7
`define BIT_AUTO_OSCILLATOR_SWITCH 4
`define BIT_COMPARATOR_POLARITY 4
`define BIT_INTERFACE_ON_BACKUP 7
`define BIT_COMPARATOR_LEVEL 7
`define BIT_EXTERNAL_RESET_ENABLE 4
`define BIT_WATCHDOG_STEERING 5
`define BIT_SLEEP_RESET_ENABLE 6
`define BIT_RESET_POLARITY 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_INTERRUPT_ENABLE_MASK 8'h00
`define RST_OSCILLATOR_SELECT_CONTROL 8'h00
`define RST_BATTERY_THRESHOLD_CONTROL 8'h00
`define RST_BACKUP_MODE_IO_CONTROL 8'h80
`define RST_PIN_OUTPUT_CONTROL 8'h10
`define RST_EXTENSION_MEMORY_SELECT 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 125
`define POWER_UP_ACCESS_DELAY_US 200
`define RESET_EXTENSION_DELAY_US 200
`define WATCHDOG_RESET_MS 60
`define POWER_UP_ACCESS_CYCLES (`POWER_UP_ACCESS_DELAY_US * `CLK_MHZ)
`define RESET_EXTENSION_CYCLES (`RESET_EXTENSION_DELAY_US * `CLK_MHZ)
`define WATCHDOG_RESET_CYCLES (`WATCHDOG_RESET_MS * 1000 * `CLK_MHZ)

`endif

// file: verilog/power_state_reset_control.v
// Power state tracking, backup switchover, battery-low detection and
// system reset generation.
// Assumes supply comparator outputs and pins arrive asynchronously from the
// analog domain; the register port is a simple synchronous strobe port.
//
// What this block does
// - Three power states; the reset state holds all registers at reset values.
// - Main supply above start leaves reset; below reset threshold returns, no backup.
// - Backup supply rising while in reset state does not change state.
// - Main below falling switch threshold with backup valid enters backup state.
// - Main above rising switch threshold returns to main state; hysteresis.
// - Backup below its reset threshold in backup state returns to reset.
// - Each entry into backup state sets the on-backup flag.
// - Crystal selected and auto switch set moves to RC while on backup.
// - Interface disabled on backup unless interface-on-backup bit is set.
// - Polarity 0 flags falling crossing, polarity 1 flags rising crossing.
// - Battery-low flag and its enable raise the interrupt request.
// - Comparator level bit follows the hysteretic comparator outputs.
// - Interface accesses blocked and ready low for the power-up delay.
// - Reset polarity bit selects output sense and powers up at 0.
// - System reset is the OR of the ungated power-up source and three enable-gated sources.
// - Reset held a further extension delay after ready rises.
// - Enabled external reset asserts while low, releases at once; enable resets to 1.
// - Steered watchdog expiry asserts reset for about 60 ms.
// - Sleep reset asserted through sleep, extended after sleep ends.
`timescale 1ns/1ps
`include "power_state_map.vh"

module power_state_reset_control #(
    parameter POWER_UP_CYCLES = `POWER_UP_ACCESS_CYCLES,
    parameter EXTENSION_CYCLES = `RESET_EXTENSION_CYCLES,
    parameter WATCHDOG_CYCLES = `WATCHDOG_RESET_CYCLES
) (
    input wire core_clk,
    input wire rst,
    input wire main_above_start,
    input wire main_above_reset,
    input wire main_above_falling_switch,
    input wire main_above_rising_switch,
    input wire backup_above_switch,
    input wire backup_above_reset,
    input wire backup_above_rising_ref,
    input wire backup_above_falling_ref,
    input wire external_reset_input_n,
    input wire watchdog_expired,
    input wire sleep_active,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg interface_enable,
    output reg use_rc_oscillator,
    output reg irq,
    output reg ready_interrupt_output,
    output reg system_reset_output,
    output reg [1:0] power_state
);

// ----------------------------------------
// States and counters
// ----------------------------------------
localparam [1:0] ST_POR = 2'h0;
localparam [1:0] ST_MAIN = 2'h1;
localparam [1:0] ST_BACKUP = 2'h2;
localparam [31:0] PU_FULL = POWER_UP_CYCLES;
localparam [31:0] EXT_FULL = EXTENSION_CYCLES;
localparam [31:0] WD_FULL = WATCHDOG_CYCLES;
localparam [23:0] PU_CNT = PU_FULL[23:0];
localparam [23:0] EXT_CNT = EXT_FULL[23:0];
localparam [23:0] WD_CNT = WD_FULL[23:0];

function [23:0] dec;
    input [23:0] v;
    begin
        dec = (v == 24'h000000) ? 24'h000000 : v - 24'h000001;
    end
endfunction

// ----------------------------------------
// Synchronisers
// ----------------------------------------
reg [8:0] sync1_q;
reg [8:0] sync2_q;
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        sync1_q <= 9'h100;
        sync2_q <= 9'h100;
    end else begin
        sync1_q <= {external_reset_input_n, backup_above_falling_ref, backup_above_rising_ref,
                    backup_above_reset, backup_above_switch, main_above_rising_switch,
                    main_above_falling_switch, main_above_reset, main_above_start};
        sync2_q <= sync1_q;
    end
end
wire s_start = sync2_q[0];
wire s_main_rst = sync2_q[1];
wire s_fall_sw = sync2_q[2];
wire s_rise_sw = sync2_q[3];
wire s_bat_sw = sync2_q[4];
wire s_bat_rst = sync2_q[5];
wire s_ref_rise = sync2_q[6];
wire s_ref_fall = sync2_q[7];
wire s_ext_n = sync2_q[8];

// ----------------------------------------
// Power state machine
// ----------------------------------------
reg [1:0] state_q;
reg [1:0] state_d;
always @* begin
    state_d = state_q;
    case (state_q)
        ST_POR: begin
            if (s_start)
                state_d = ST_MAIN;
        end
        ST_MAIN: begin
            if (s_bat_sw && !s_fall_sw)
                state_d = ST_BACKUP;
            else if (!s_bat_sw && !s_main_rst)
                state_d = ST_POR;
        end
        ST_BACKUP: begin
            if (!s_bat_rst)
                state_d = ST_POR;
            else if (s_rise_sw)
                state_d = ST_MAIN;
        end
        default: state_d = ST_POR;
    endcase
end
wire in_por = (state_q == ST_POR);
wire enter_backup = (state_d == ST_BACKUP) && (state_q != ST_BACKUP);
wire power_up = (state_q == ST_POR) && (state_d == ST_MAIN);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] irq_mask_q;
reg [7:0] osc_ctrl_q;
reg [7:0] comparator_threshold_select_ctrl_q;
reg [7:0] batmode_q;
reg [7:0] out_ctrl_q;
reg [7:0] ext_sel_q;
reg on_backup_flag_q;
reg battery_low_flag_q;
reg comparator_level_q;
reg [23:0] pu_cnt_q;
reg access_ok_q;
wire wr_ok = reg_wr && access_ok_q && interface_enable;
wire wr_status = wr_ok && (reg_addr == `OFS_EVENT_STATUS_FLAGS);
wire polarity = comparator_threshold_select_ctrl_q[`BIT_COMPARATOR_POLARITY];
wire cmp_fall = comparator_level_q && !s_ref_fall;
wire cmp_rise = !comparator_level_q && s_ref_rise;

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        state_q <= ST_POR;
        irq_mask_q <= `RST_INTERRUPT_ENABLE_MASK;
        osc_ctrl_q <= `RST_OSCILLATOR_SELECT_CONTROL;
        comparator_threshold_select_ctrl_q <= `RST_BATTERY_THRESHOLD_CONTROL;
        batmode_q <= `RST_BACKUP_MODE_IO_CONTROL;
        out_ctrl_q <= `RST_PIN_OUTPUT_CONTROL;
        ext_sel_q <= `RST_EXTENSION_MEMORY_SELECT;
        on_backup_flag_q <= 1'b0;
        battery_low_flag_q <= 1'b0;
        comparator_level_q <= 1'b0;
    end else begin
        state_q <= state_d;
        if (in_por) begin
            irq_mask_q <= `RST_INTERRUPT_ENABLE_MASK;
            osc_ctrl_q <= `RST_OSCILLATOR_SELECT_CONTROL;
            comparator_threshold_select_ctrl_q <= `RST_BATTERY_THRESHOLD_CONTROL;
            batmode_q <= `RST_BACKUP_MODE_IO_CONTROL;
            out_ctrl_q <= `RST_PIN_OUTPUT_CONTROL;
            ext_sel_q <= `RST_EXTENSION_MEMORY_SELECT;
            on_backup_flag_q <= 1'b0;
            battery_low_flag_q <= 1'b0;
            comparator_level_q <= 1'b0;
        end else begin
            if (wr_ok) begin
                case (reg_addr)
                    `OFS_INTERRUPT_ENABLE_MASK: irq_mask_q <= reg_wdata;
                    `OFS_OSCILLATOR_SELECT_CONTROL: osc_ctrl_q <= reg_wdata;
                    `OFS_BATTERY_THRESHOLD_CONTROL: comparator_threshold_select_ctrl_q <= reg_wdata;
                    `OFS_BACKUP_MODE_IO_CONTROL: batmode_q <= reg_wdata;
                    `OFS_PIN_OUTPUT_CONTROL: out_ctrl_q <= reg_wdata;
                    `OFS_EXTENSION_MEMORY_SELECT: ext_sel_q <= reg_wdata;
                    default: ;
                endcase
            end
            // Hardware set wins over a software clear in the same cycle
            if (enter_backup)
                on_backup_flag_q <= 1'b1;
            else if (wr_status && !reg_wdata[`BIT_ON_BACKUP_FLAG])
                on_backup_flag_q <= 1'b0;
            if ((!polarity && cmp_fall) || (polarity && cmp_rise))
                battery_low_flag_q <= 1'b1;
            else if (wr_status && !reg_wdata[`BIT_BATTERY_LOW_FLAG])
                battery_low_flag_q <= 1'b0;
            if (cmp_fall)
                comparator_level_q <= 1'b0;
            else if (cmp_rise)
                comparator_level_q <= 1'b1;
        end
    end
end

// ----------------------------------------
// Power-up access delay
// ----------------------------------------
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        pu_cnt_q <= 24'h000000;
        access_ok_q <= 1'b0;
    end else if (in_por) begin
        pu_cnt_q <= PU_CNT;
        access_ok_q <= 1'b0;
    end else if (power_up || pu_cnt_q != 24'h000000) begin
        pu_cnt_q <= dec(pu_cnt_q);
        access_ok_q <= (pu_cnt_q == 24'h000001);
    end
end

// ----------------------------------------
// Reset sources
// ----------------------------------------
reg [23:0] ext_cnt_q;
reg [23:0] wd_cnt_q;
reg access_seen_q;
reg sleep_q;
wire rs_ext_en = out_ctrl_q[`BIT_EXTERNAL_RESET_ENABLE];
wire rs_wd_en = out_ctrl_q[`BIT_WATCHDOG_STEERING];
wire rs_sleep_en = out_ctrl_q[`BIT_SLEEP_RESET_ENABLE];
wire sleep_exit = sleep_q && !sleep_active && rs_sleep_en;
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        ext_cnt_q <= 24'h000000;
        wd_cnt_q <= 24'h000000;
        access_seen_q <= 1'b0;
        sleep_q <= 1'b0;
    end else begin
        access_seen_q <= access_ok_q && !in_por;
        sleep_q <= sleep_active;
        if (in_por)
            ext_cnt_q <= 24'h000000;
        else if ((access_ok_q && !access_seen_q) || sleep_exit)
            ext_cnt_q <= EXT_CNT;
        else
            ext_cnt_q <= dec(ext_cnt_q);
        if (watchdog_expired && rs_wd_en)
            wd_cnt_q <= WD_CNT;
        else
            wd_cnt_q <= dec(wd_cnt_q);
    end
end
// Load cycles of the extension counter count as asserted, so no one-cycle release
wire reset_asserted = !access_ok_q || (ext_cnt_q != 24'h000000) ||
                      (access_ok_q && !access_seen_q) || sleep_exit ||
                      (rs_ext_en && !s_ext_n) ||
                      (wd_cnt_q != 24'h000000) ||
                      (rs_sleep_en && sleep_active);

// ----------------------------------------
// Outputs and read port
// ----------------------------------------
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        reg_rdata <= 8'h00;
        interface_enable <= 1'b0;
        use_rc_oscillator <= 1'b0;
        irq <= 1'b0;
        ready_interrupt_output <= 1'b0;
        system_reset_output <= 1'b0;
        power_state <= ST_POR;
    end else begin
        power_state <= state_q;
        interface_enable <= access_ok_q &&
            !(state_q == ST_BACKUP && !batmode_q[`BIT_INTERFACE_ON_BACKUP]);
        use_rc_oscillator <= osc_ctrl_q[`BIT_OSC_SELECT_RC] ||
            (state_q == ST_BACKUP && osc_ctrl_q[`BIT_AUTO_OSCILLATOR_SWITCH]);
        irq <= battery_low_flag_q && irq_mask_q[`BIT_BATTERY_LOW_IRQ_ENABLE];
        ready_interrupt_output <= access_ok_q;
        system_reset_output <= out_ctrl_q[`BIT_RESET_POLARITY] ?
            reset_asserted : !reset_asserted;
        reg_rdata <= 8'h00;
        if (reg_rd && access_ok_q && interface_enable) begin
            case (reg_addr)
                `OFS_EVENT_STATUS_FLAGS: reg_rdata <= {on_backup_flag_q, 2'b00,
                    battery_low_flag_q, 4'h0};
                `OFS_INTERRUPT_ENABLE_MASK: reg_rdata <= irq_mask_q;
                `OFS_OSCILLATOR_SELECT_CONTROL: reg_rdata <= osc_ctrl_q;
                `OFS_BATTERY_THRESHOLD_CONTROL: reg_rdata <= comparator_threshold_select_ctrl_q;
                `OFS_BACKUP_MODE_IO_CONTROL: reg_rdata <= batmode_q;
                `OFS_COMPARATOR_LEVEL_STATUS: reg_rdata <= {comparator_level_q, 7'h00};
                `OFS_PIN_OUTPUT_CONTROL: reg_rdata <= out_ctrl_q;
                `OFS_EXTENSION_MEMORY_SELECT: reg_rdata <= ext_sel_q;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
end

endmodule // power_state_reset_control

// file: tb/power_state_reset_control_properties.sv
// Port-level checker for the power state and reset control block.
// Assumes binding into the block; supply inputs pass two sync stages.
`timescale 1ns/1ps
module power_state_checker #(
    parameter POWER_UP_CYCLES = 20,
    parameter EXTENSION_CYCLES = 10,
    parameter WATCHDOG_CYCLES = 30
) (
    input wire core_clk,
    input wire rst,
    input wire main_above_start,
    input wire main_above_reset,
    input wire main_above_falling_switch,
    input wire main_above_rising_switch,
    input wire backup_above_switch,
    input wire backup_above_reset,
    input wire backup_above_rising_ref,
    input wire backup_above_falling_ref,
    input wire external_reset_input_n,
    input wire watchdog_expired,
    input wire sleep_active,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire interface_enable,
    input wire use_rc_oscillator,
    input wire irq,
    input wire ready_interrupt_output,
    input wire system_reset_output,
    input wire [1:0] power_state
);
    int wait_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Cycles spent in the main state with ready still low
    // ------------------------------------------------------------
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            wait_q <= 0;
        else if (power_state == 2'h1 && !ready_interrupt_output)
            wait_q <= wait_q + 1;
        else
            wait_q <= 0;
    end
    AST_STATE_CODE: assert property (power_state != 2'h3) else $error("bad state code");
    AST_POR_EXIT: assert property (($past(power_state) == 2'h0 && power_state != 2'h0) |->
        power_state == 2'h1 && ($past(main_above_start, 2) || $past(main_above_start, 3)
        || $past(main_above_start, 4))) else $error("bad exit from reset state");
    AST_MAIN_TO_POR: assert property (($past(power_state) == 2'h1 && power_state == 2'h0) |->
        !($past(main_above_reset, 2) && $past(main_above_reset, 3) && $past(main_above_reset, 4)))
        else $error("reset state entered with main supply good");
    AST_TO_BACKUP: assert property (($past(power_state) == 2'h1 && power_state == 2'h2) |->
        !($past(main_above_falling_switch, 2) && $past(main_above_falling_switch, 3)
        && $past(main_above_falling_switch, 4))) else $error("backup entered with main good");
    AST_BACK_TO_MAIN: assert property (($past(power_state) == 2'h2 && power_state == 2'h1) |->
        ($past(main_above_rising_switch, 2) || $past(main_above_rising_switch, 3)
        || $past(main_above_rising_switch, 4))) else $error("main entered below rising switch");
    AST_BACKUP_TO_POR: assert property (($past(power_state) == 2'h2 && power_state == 2'h0) |->
        !($past(backup_above_reset, 2) && $past(backup_above_reset, 3) && $past(backup_above_reset, 4)))
        else $error("reset state entered with backup good");
    AST_POR_QUIET: assert property (($past(power_state) == 2'h0 && power_state == 2'h0) |->
        !ready_interrupt_output && !interface_enable && !system_reset_output)
        else $error("outputs active in reset state");
    AST_READY_LATE: assert property (wait_q <= POWER_UP_CYCLES + 3) else $error("ready late");
    AST_READY_EARLY: assert property ($rose(ready_interrupt_output) && power_state == 2'h1 |->
        $past(wait_q) >= POWER_UP_CYCLES - 3) else $error("ready early");
    AST_GATED_UNTIL_READY: assert property (power_state == 2'h1 && !ready_interrupt_output |->
        !interface_enable) else $error("interface open before ready");
    AST_HOLD_AFTER_READY: assert property ($rose(ready_interrupt_output) |->
        !system_reset_output [*2]) else $error("reset released with ready");
    AST_READ_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stale read data");
    COV_BACKUP: cover property ($past(power_state) == 2'h1 && power_state == 2'h2);
    COV_READY: cover property ($rose(ready_interrupt_output));
    COV_IRQ: cover property ($rose(irq));
endmodule // power_state_checker

bind power_state_reset_control power_state_checker #(.POWER_UP_CYCLES(POWER_UP_CYCLES),
    .EXTENSION_CYCLES(EXTENSION_CYCLES), .WATCHDOG_CYCLES(WATCHDOG_CYCLES)) power_state_checker_inst (.*);

// file: tb/host_link_model.sv
// Host controller model: grants serial access once the ready output is high.
// Assumes the block's core clock and reset.
`timescale 1ns/1ps
module host_link_model (
    input wire core_clk,
    input wire rst,
    input wire ready_interrupt_output,
    output reg host_may_access
);
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            host_may_access <= 1'b0;
        else if (ready_interrupt_output)
            host_may_access <= 1'b1;
    end
endmodule // host_link_model

// file: tb/tb_power_state_reset_control.sv
// Self-checking bench for the power state and reset control block.
// Assumes short counts: power-up 20, extension 10, watchdog 30 cycles.
`timescale 1ns/1ps
module tb_power_state_reset_control;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic main_above_start = 1'b0, main_above_reset = 1'b0;
    logic main_above_falling_switch = 1'b0, main_above_rising_switch = 1'b0;
    logic backup_above_switch = 1'b0, backup_above_reset = 1'b0;
    logic backup_above_rising_ref = 1'b0, backup_above_falling_ref = 1'b0;
    logic external_reset_input_n = 1'b1, watchdog_expired = 1'b0, sleep_active = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    wire [7:0] reg_rdata;
    wire [1:0] power_state;
    wire interface_enable, use_rc_oscillator, irq, ready_interrupt_output;
    wire system_reset_output, host_may_access;
    int n_fail = 0, compares = 0, cycles = 0, i;
    power_state_reset_control #(.POWER_UP_CYCLES(20), .EXTENSION_CYCLES(10), .WATCHDOG_CYCLES(30))
        power_state_reset_control_inst (.*);
    host_link_model host_link_model_inst (.core_clk(core_clk), .rst(rst),
        .ready_interrupt_output(ready_interrupt_output), .host_may_access(host_may_access));
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict;
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task give_verdict;
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input [7:0] seen, input [7:0] want);
        compares++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge core_clk) reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] want);
        @(posedge core_clk) reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk) reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, want);
    endtask
    task wait_for(input [1:0] s);
        for (i = 0; i < 60 && power_state !== s; i++) @(posedge core_clk);
        #1;
        chk(power_state, s);
    endtask
    // Start, reset, falling switch, rising switch comparator levels
    task set_main(input [3:0] v);
        @(posedge core_clk) {main_above_start, main_above_reset} <= v[3:2];
        {main_above_falling_switch, main_above_rising_switch} <= v[1:0];
    endtask
    task pulse_watchdog;
        @(posedge core_clk) watchdog_expired <= 1'b1;
        @(posedge core_clk) watchdog_expired <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_power_up;
        @(posedge core_clk) backup_above_switch <= 1'b1;
        backup_above_reset <= 1'b1;
        cyc(10);
        chk({power_state, ready_interrupt_output, system_reset_output}, 8'h00);
        set_main(4'hF);
        wait_for(2'h1);
        for (i = 0; i < 60 && host_may_access !== 1'b1; i++) @(posedge core_clk);
        #1;
        chk({ready_interrupt_output, system_reset_output}, 8'h02);
        for (i = 0; i < 40 && system_reset_output !== 1'b1; i++) @(posedge core_clk);
        #1;
        chk(i > 6 && i < 14, 8'h01);
    endtask
    task automatic t_regs;
        logic [15:0] tbl [8] = '{16'h2780, 16'h3010, 16'h1200, 16'h1C00, 16'h2100, 16'h3F00,
            16'h0F00, 16'h0100};
        foreach (tbl[k]) rd(tbl[k][15:8], tbl[k][7:0]);
        wr(8'h12, 8'h10);
        rd(8'h12, 8'h10);
    endtask
    task automatic t_ext_reset;
        logic [7:0] ctl [3] = '{8'h10, 8'h00, 8'h90};
        logic [7:0] want [3] = '{8'h00, 8'h01, 8'h01};
        foreach (ctl[k]) begin
            wr(8'h30, ctl[k]);
            @(posedge core_clk) external_reset_input_n <= 1'b0;
            cyc(6);
            chk(system_reset_output, want[k]);
            @(posedge core_clk) external_reset_input_n <= 1'b1;
            cyc(5);
            chk(system_reset_output, ctl[k][7] ? 8'h00 : 8'h01);
        end
    endtask
    task t_watchdog_sleep;
        wr(8'h30, 8'h10);
        pulse_watchdog;
        cyc(5);
        chk(system_reset_output, 8'h01);
        wr(8'h30, 8'h30);
        pulse_watchdog;
        cyc(25);
        chk(system_reset_output, 8'h00);
        cyc(15);
        chk(system_reset_output, 8'h01);
        wr(8'h30, 8'h50);
        @(posedge core_clk) sleep_active <= 1'b1;
        cyc(20);
        chk(system_reset_output, 8'h00);
        @(posedge core_clk) sleep_active <= 1'b0;
        cyc(7);
        chk(system_reset_output, 8'h00);
        cyc(10);
        chk(system_reset_output, 8'h01);
    endtask
    task t_batt_low;
        @(posedge core_clk) backup_above_rising_ref <= 1'b1;
        backup_above_falling_ref <= 1'b1;
        cyc(5);
        rd(8'h2F, 8'h80);
        wr(8'h0F, 8'h00);
        @(posedge core_clk) backup_above_falling_ref <= 1'b0;
        backup_above_rising_ref <= 1'b0;
        cyc(5);
        chk(irq, 8'h01);
        rd(8'h2F, 8'h00);
        rd(8'h0F, 8'h10);
        wr(8'h21, 8'h10);
        wr(8'h0F, 8'h00);
        cyc(2);
        chk(irq, 8'h00);
        @(posedge core_clk) backup_above_falling_ref <= 1'b1;
        cyc(5);
        chk(irq, 8'h00);
        rd(8'h2F, 8'h00);
        @(posedge core_clk) backup_above_rising_ref <= 1'b1;
        cyc(5);
        chk(irq, 8'h01);
        rd(8'h2F, 8'h80);
        wr(8'h0F, 8'h00);
    endtask
    task t_backup;
        wr(8'h1C, 8'h10);
        set_main(4'hC);
        wait_for(2'h2);
        chk({use_rc_oscillator, interface_enable}, 8'h03);
        rd(8'h0F, 8'h80);
        wr(8'h27, 8'h00);
        cyc(2);
        chk(interface_enable, 8'h00);
        set_main(4'hE);
        cyc(8);
        chk(power_state, 8'h02);
        set_main(4'hF);
        wait_for(2'h1);
        chk({use_rc_oscillator, interface_enable}, 8'h01);
        set_main(4'h4);
        wait_for(2'h2);
        @(posedge core_clk) backup_above_reset <= 1'b0;
        wait_for(2'h0);
        chk(ready_interrupt_output, 8'h00);
        @(posedge core_clk) backup_above_switch <= 1'b0;
        set_main(4'hF);
        wait_for(2'h1);
        set_main(4'h0);
        wait_for(2'h0);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_power_up;
        t_regs;
        t_ext_reset;
        t_watchdog_sleep;
        t_batt_low;
        t_backup;
        give_verdict;
    end
endmodule // tb_power_state_reset_control
